//--- rtl/ubr_brg.sv
// ubr_brg: 8-bit reload up-counter that produces one-cycle overflow ticks.
// assumes controls come from registers on the same clock.
`timescale 1ns/10ps
module ubr_brg (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic fast,
  input wire logic [7:0] reload,
  output logic tick
);
  logic [2:0] pre_reg;
  logic [7:0] cnt_reg;
  logic step;

  // slow mode steps once every six clocks, fast mode every clock
  assign step = run && (fast || pre_reg == ubr_pkg::UBR_SLOW_LAST);

  // ==========================================================================
  // divide-by-six prescaler, held clear when stopped or fast
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= ubr_pkg::UBR_PRE_ZERO;
    end else if (ce) begin
      if (!run || fast || pre_reg == ubr_pkg::UBR_SLOW_LAST) begin
        pre_reg <= ubr_pkg::UBR_PRE_ZERO;
      end else begin
        pre_reg <= pre_reg + 3'h1;
      end
    end
  end

  // ==========================================================================
  // counter with reload on ff to the reload value and one-cycle tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= ubr_pkg::UBR_RST_BYTE;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= step && cnt_reg == ubr_pkg::UBR_BRG_TOP;
      if (step) begin
        if (cnt_reg == ubr_pkg::UBR_BRG_TOP) begin
          cnt_reg <= reload;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule

//--- rtl/ubr_pkg.sv
// ubr_pkg: register map, field positions, reset values and timing constants
// for the uart baud source and framing block.
// assumes an ahb-lite slave with 32-bit data, one register per aligned word.
package ubr_pkg;

  // ==========================================================================
  // register word indexes, the byte address is four times the index
  localparam logic [7:0] UBR_IDX_RELOAD = 8'h9a;
  localparam logic [7:0] UBR_IDX_RATECTL = 8'h9b;
  localparam logic [7:0] UBR_IDX_T2CTL = 8'h00;
  localparam logic [7:0] UBR_IDX_T2RLO = 8'h01;
  localparam logic [7:0] UBR_IDX_T2RHI = 8'h02;
  localparam logic [7:0] UBR_IDX_SERCTL = 8'h03;
  localparam logic [7:0] UBR_IDX_PWRCTL = 8'h04;
  localparam logic [7:0] UBR_IDX_STATUS = 8'h05;
  localparam int UBR_ADDR_W = 10;

  // ==========================================================================
  // rate_generator_control fields
  localparam int UBR_RC_RUN = 4;
  localparam int UBR_RC_TX = 3;
  localparam int UBR_RC_RX = 2;
  localparam int UBR_RC_FAST = 1;
  localparam int UBR_RC_M0SRC = 0;
  localparam int UBR_RC_W = 5;

  // timer2_control fields
  localparam int UBR_T2_TXSEL = 4;
  localparam int UBR_T2_RXSEL = 5;
  localparam int UBR_T2_RUN = 2;

  // power_control fields
  localparam int UBR_PC_DOUBLE = 7;
  localparam int UBR_PC_FESEL = 6;

  // serial_control fields
  localparam int UBR_SC_TOP = 7;

  // status fields
  localparam int UBR_ST_FE = 0;
  localparam int UBR_ST_BRG = 1;
  localparam int UBR_ST_T2 = 2;

  // ==========================================================================
  // reset values and counts
  localparam logic [7:0] UBR_RST_BYTE = 8'h00;
  localparam logic [15:0] UBR_RST_WORD = 16'h0000;
  localparam logic [7:0] UBR_BRG_TOP = 8'hff;
  localparam logic [15:0] UBR_T2_TOP = 16'hffff;
  localparam int UBR_SLOW_DIV = 6;
  localparam logic [2:0] UBR_SLOW_LAST = 3'(UBR_SLOW_DIV - 1);
  localparam logic [2:0] UBR_PRE_ZERO = 3'h0;
  localparam logic [1:0] UBR_HTRANS_NONSEQ = 2'h2;

endpackage

//--- rtl/ubr_sync.sv
// ubr_sync: two flip-flop synchroniser for one asynchronous level.
// assumes one clock, asynchronous active-low reset.
`timescale 1ns/10ps
module ubr_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_reg;

  // ==========================================================================
  // first stage is read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

//--- rtl/ubr_top.sv
// ubr_top: baud source selection, timer 2 baud mode, internal rate counter
// and framing error flag for a uart, behind an ahb-lite register slave.
// assumes timer 1 overflow and mode 0 fixed clock arrive as one-cycle pulses
// on hclk; frame done arrives from the receiver on hclk, the stop bit level asynchronously from the line.
// Functional notes
// - timer 2 feeds tx/rx when selected
// - tx and rx may use different timers
// - timer 2 rollover reloads 16-bit value
// - timer 2 rate is fsys/(65536-reload)
// - prescale and double speed ignored in baud mode
// - rate counter 8-bit, reloads on overflow
// - rate counter counts only while run set
// - slow mode divides clock by six
// - counter ignores prescaler, doubling scales output
// - tx clock from counter when selected
// - rx clock from counter when selected
// - counter selects beat timer 2 selects
// - mode 0 clock from counter when selected
// - control register bits 4..0, reset zero
// - reload register resets to zero
// - missing stop bit sets framing flag
// - serial bit 7 muxed by select bit
// - flag set always, cleared only by software
// - doubling bit lives at power bit 7
// - default source is timer 1
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module ubr_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer1_ovf,
  input wire logic mode0_fixed_tick,
  input wire logic rx_frame_done,
  input wire logic rx_stop_bit,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  output logic mode0_tick,
  output logic baud_doubling,
  output logic serial_mode_bit0
);
  logic [7:0] rate_reload_value_reg;
  logic [ubr_pkg::UBR_RC_W-1:0] rate_generator_control_reg;
  logic [7:0] timer2_control_reg;
  logic [7:0] timer2_reload_low_reg;
  logic [7:0] timer2_reload_high_reg;
  logic [6:0] serial_control_low_reg;
  logic sm0_reg;
  logic framing_error_flag_reg;
  logic [7:0] power_control_reg;
  logic [15:0] t2_cnt_reg;
  logic t2_tick_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [31:0] hrdata_next;
  logic brg_tick;
  logic stop_sync;
  logic framing_evt;
  logic t2_baud_mode;
  logic sc7_write;
  logic [7:0] rd_idx;
  logic [7:0] wbyte;

  assign wbyte = hwdata[7:0];
  assign rd_idx = haddr[ubr_pkg::UBR_ADDR_W-1:2];

  // ==========================================================================
  // stop bit level comes from the line, so synchronise it
  ubr_sync u_stop_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d(rx_stop_bit),
    .q(stop_sync)
  );

  // internal rate counter
  ubr_brg u_brg (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .run(rate_generator_control_reg[ubr_pkg::UBR_RC_RUN]),
    .fast(rate_generator_control_reg[ubr_pkg::UBR_RC_FAST]),
    .reload(rate_reload_value_reg),
    .tick(brg_tick)
  );

  // ==========================================================================
  // ahb-lite: writes land in the data phase, reads answer with zero wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= ubr_pkg::UBR_RST_BYTE;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      if (hready) begin
        wr_pend_reg <= hsel && htrans[1] && hwrite;
        wr_idx_reg <= rd_idx;
        hrdata <= hrdata_next;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0; // response is always okay
    end
  end

  // read mux, unmapped words read as zero
  always_comb begin
    hrdata_next = 32'h00000000;
    if (hsel && htrans[1] && !hwrite) begin
      unique case (rd_idx)
        ubr_pkg::UBR_IDX_RELOAD: hrdata_next[7:0] = rate_reload_value_reg;
        ubr_pkg::UBR_IDX_RATECTL: hrdata_next[4:0] = rate_generator_control_reg;
        ubr_pkg::UBR_IDX_T2CTL: hrdata_next[7:0] = timer2_control_reg;
        ubr_pkg::UBR_IDX_T2RLO: hrdata_next[7:0] = timer2_reload_low_reg;
        ubr_pkg::UBR_IDX_T2RHI: hrdata_next[7:0] = timer2_reload_high_reg;
        ubr_pkg::UBR_IDX_SERCTL: begin
          hrdata_next[7:0] = {(power_control_reg[ubr_pkg::UBR_PC_FESEL] ?
            framing_error_flag_reg : sm0_reg), serial_control_low_reg};
        end
        ubr_pkg::UBR_IDX_PWRCTL: hrdata_next[7:0] = power_control_reg;
        ubr_pkg::UBR_IDX_STATUS: begin
          hrdata_next[ubr_pkg::UBR_ST_FE] = framing_error_flag_reg;
          hrdata_next[ubr_pkg::UBR_ST_BRG] = brg_tick;
          hrdata_next[ubr_pkg::UBR_ST_T2] = t2_baud_mode;
        end
        default: hrdata_next = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // software-written registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_reload_value_reg <= ubr_pkg::UBR_RST_BYTE;
      rate_generator_control_reg <= '0;
      timer2_control_reg <= ubr_pkg::UBR_RST_BYTE;
      timer2_reload_low_reg <= ubr_pkg::UBR_RST_BYTE;
      timer2_reload_high_reg <= ubr_pkg::UBR_RST_BYTE;
      serial_control_low_reg <= '0;
      sm0_reg <= 1'b0;
      power_control_reg <= ubr_pkg::UBR_RST_BYTE;
    end else if (ce && wr_pend_reg) begin
      unique case (wr_idx_reg)
        ubr_pkg::UBR_IDX_RELOAD: rate_reload_value_reg <= wbyte;
        ubr_pkg::UBR_IDX_RATECTL: rate_generator_control_reg <= wbyte[4:0];
        ubr_pkg::UBR_IDX_T2CTL: timer2_control_reg <= wbyte;
        ubr_pkg::UBR_IDX_T2RLO: timer2_reload_low_reg <= wbyte;
        ubr_pkg::UBR_IDX_T2RHI: timer2_reload_high_reg <= wbyte;
        ubr_pkg::UBR_IDX_SERCTL: begin
          serial_control_low_reg <= wbyte[6:0];
          if (!power_control_reg[ubr_pkg::UBR_PC_FESEL]) begin
            sm0_reg <= wbyte[ubr_pkg::UBR_SC_TOP];
          end
        end
        ubr_pkg::UBR_IDX_PWRCTL: power_control_reg <= wbyte;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // framing error: set on a frame with no stop bit, set beats clear
  assign framing_evt = rx_frame_done && !stop_sync;
  assign sc7_write = wr_pend_reg && wr_idx_reg == ubr_pkg::UBR_IDX_SERCTL &&
    power_control_reg[ubr_pkg::UBR_PC_FESEL];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      framing_error_flag_reg <= 1'b0;
    end else if (ce) begin
      if (framing_evt) begin
        framing_error_flag_reg <= 1'b1;
      end else if (sc7_write) begin
        framing_error_flag_reg <= wbyte[ubr_pkg::UBR_SC_TOP];
      end
    end
  end

  // ==========================================================================
  // timer 2 in baud mode with its run bit set counts every clock, no prescale or doubling
  assign t2_baud_mode = timer2_control_reg[ubr_pkg::UBR_T2_TXSEL] ||
    timer2_control_reg[ubr_pkg::UBR_T2_RXSEL];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t2_cnt_reg <= ubr_pkg::UBR_RST_WORD;
      t2_tick_reg <= 1'b0;
    end else if (ce) begin
      t2_tick_reg <= 1'b0;
      if (t2_baud_mode && timer2_control_reg[ubr_pkg::UBR_T2_RUN]) begin
        if (t2_cnt_reg == ubr_pkg::UBR_T2_TOP) begin
          t2_cnt_reg <= {timer2_reload_high_reg, timer2_reload_low_reg};
          t2_tick_reg <= 1'b1;
        end else begin
          t2_cnt_reg <= t2_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // per-direction source selection, counter over timer 2 over timer 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
      mode0_tick <= 1'b0;
      baud_doubling <= 1'b0;
      serial_mode_bit0 <= 1'b0;
    end else if (ce) begin
      if (rate_generator_control_reg[ubr_pkg::UBR_RC_TX]) begin
        tx_baud_tick <= brg_tick;
      end else if (timer2_control_reg[ubr_pkg::UBR_T2_TXSEL]) begin
        tx_baud_tick <= t2_tick_reg;
      end else begin
        tx_baud_tick <= timer1_ovf;
      end
      if (rate_generator_control_reg[ubr_pkg::UBR_RC_RX]) begin
        rx_baud_tick <= brg_tick;
      end else if (timer2_control_reg[ubr_pkg::UBR_T2_RXSEL]) begin
        rx_baud_tick <= t2_tick_reg;
      end else begin
        rx_baud_tick <= timer1_ovf;
      end
      mode0_tick <= rate_generator_control_reg[ubr_pkg::UBR_RC_M0SRC] ?
        brg_tick : mode0_fixed_tick;
      baud_doubling <= power_control_reg[ubr_pkg::UBR_PC_DOUBLE];
      serial_mode_bit0 <= sm0_reg;
    end
  end

  // ==========================================================================
  // checks
  property p_fe_set;
    @(posedge hclk) disable iff (!hresetn)
      ce && framing_evt |=> framing_error_flag_reg;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing flag not set");

  property p_fe_sticky;
    @(posedge hclk) disable iff (!hresetn)
      framing_error_flag_reg && !sc7_write |=> framing_error_flag_reg;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("framing flag cleared itself");

  property p_tx_brg;
    @(posedge hclk) disable iff (!hresetn)
      ce && rate_generator_control_reg[ubr_pkg::UBR_RC_TX] && brg_tick
      && !wr_pend_reg |=> tx_baud_tick;
  endproperty
  a_tx_brg: assert property (p_tx_brg) else $error("tx tick missing from counter");

  property p_rx_brg;
    @(posedge hclk) disable iff (!hresetn)
      ce && rate_generator_control_reg[ubr_pkg::UBR_RC_RX] && !brg_tick |=> !rx_baud_tick;
  endproperty
  a_rx_brg: assert property (p_rx_brg) else $error("rx tick not from counter");

  property p_t2_reload;
    @(posedge hclk) disable iff (!hresetn)
      ce && t2_tick_reg |-> t2_cnt_reg == {$past(timer2_reload_high_reg),
      $past(timer2_reload_low_reg)};
  endproperty
  a_t2_reload: assert property (p_t2_reload) else $error("timer 2 reload wrong");

  property p_t2_tick_pulse;
    @(posedge hclk) disable iff (!hresetn)
      ce && t2_tick_reg &&
      {timer2_reload_high_reg, timer2_reload_low_reg} != ubr_pkg::UBR_T2_TOP |=> !t2_tick_reg;
  endproperty
  a_t2_tick_pulse: assert property (p_t2_tick_pulse) else $error("timer 2 tick too wide");

  property p_brg_stop;
    @(posedge hclk) disable iff (!hresetn)
      !rate_generator_control_reg[ubr_pkg::UBR_RC_RUN] [*2] |-> !brg_tick;
  endproperty
  a_brg_stop: assert property (p_brg_stop) else $error("counter ticks while stopped");

  property p_tx_t1;
    @(posedge hclk) disable iff (!hresetn)
      ce && !wr_pend_reg && rate_generator_control_reg == '0 &&
      timer2_control_reg == ubr_pkg::UBR_RST_BYTE && timer1_ovf |=> tx_baud_tick;
  endproperty
  a_tx_t1: assert property (p_tx_t1) else $error("timer 1 default lost");

  property p_sc7_read;
    @(posedge hclk) disable iff (!hresetn)
      ce && hready && hsel && htrans == ubr_pkg::UBR_HTRANS_NONSEQ && !hwrite &&
      rd_idx == ubr_pkg::UBR_IDX_SERCTL && power_control_reg[ubr_pkg::UBR_PC_FESEL]
      |=> hrdata[ubr_pkg::UBR_SC_TOP] == $past(framing_error_flag_reg);
  endproperty
  a_sc7_read: assert property (p_sc7_read) else $error("bit 7 read mux wrong");

  // timer 2 feeds tx when selected and the counter is not
  property p_tx_t2;
    @(posedge hclk) disable iff (!hresetn)
      ce && !rate_generator_control_reg[ubr_pkg::UBR_RC_TX] &&
      timer2_control_reg[ubr_pkg::UBR_T2_TXSEL] && t2_tick_reg |=> tx_baud_tick;
  endproperty
  a_tx_t2: assert property (p_tx_t2) else $error("tx tick missing from timer 2");

  // rx on timer 2 while tx is not selected to timer 2
  property p_rx_t2;
    @(posedge hclk) disable iff (!hresetn)
      ce && !rate_generator_control_reg[ubr_pkg::UBR_RC_RX] &&
      !timer2_control_reg[ubr_pkg::UBR_T2_TXSEL] &&
      timer2_control_reg[ubr_pkg::UBR_T2_RXSEL] && t2_tick_reg |=> rx_baud_tick;
  endproperty
  a_rx_t2: assert property (p_rx_t2) else $error("rx tick lost from timer 2");

  property p_m0_brg;
    @(posedge hclk) disable iff (!hresetn)
      ce && rate_generator_control_reg[ubr_pkg::UBR_RC_M0SRC] && brg_tick |=> mode0_tick;
  endproperty
  a_m0_brg: assert property (p_m0_brg) else $error("mode 0 tick missing from counter");

  property p_brg_pulse;
    @(posedge hclk) disable iff (!hresetn)
      ce && brg_tick && rate_reload_value_reg != ubr_pkg::UBR_BRG_TOP |=> !brg_tick;
  endproperty
  a_brg_pulse: assert property (p_brg_pulse) else $error("counter tick too wide");

  property p_dbl_copy;
    @(posedge hclk) disable iff (!hresetn)
      ce |=> baud_doubling == $past(power_control_reg[ubr_pkg::UBR_PC_DOUBLE]);
  endproperty
  a_dbl_copy: assert property (p_dbl_copy) else $error("doubling output stale");

  // a bit 7 write under the flag view leaves the mode bit alone
  property p_sm0_keep;
    @(posedge hclk) disable iff (!hresetn)
      ce && wr_pend_reg && wr_idx_reg == ubr_pkg::UBR_IDX_SERCTL &&
      power_control_reg[ubr_pkg::UBR_PC_FESEL] |=> $stable(sm0_reg);
  endproperty
  a_sm0_keep: assert property (p_sm0_keep) else $error("mode bit written under flag view");

  // clock enable low freezes registers, counters and the flag
  property p_ce_hold;
    @(posedge hclk) disable iff (!hresetn)
      !ce |=> $stable(power_control_reg) && $stable(t2_cnt_reg) &&
      $stable(framing_error_flag_reg) && $stable(tx_baud_tick);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved with clock enable low");

endmodule

//--- testbench/ubr_far_end.sv
// ubr_far_end: remote serial sender as seen at the receiver side of the block.
// assumes hclk from the bench; each frame ends with a one-cycle done pulse.
`timescale 1ns/10ps
module ubr_far_end (
  input wire logic hclk,
  output logic rx_stop_bit,
  output logic rx_frame_done
);
  // ==========================================================================
  // idle line rests at mark, no frame in flight
  initial begin
    rx_stop_bit = 1'h1;
    rx_frame_done = 1'h0;
  end

  // ==========================================================================
  // one frame: stop level settles through the synchroniser, then done pulses
  task automatic send_frame(input logic stop);
    rx_stop_bit <= stop;
    repeat (4) @(posedge hclk);
    rx_frame_done <= 1'h1;
    @(posedge hclk);
    rx_frame_done <= 1'h0;
    repeat (2) @(posedge hclk);
    rx_stop_bit <= 1'h1; // line back to idle mark
  endtask
endmodule

//--- testbench/ubr_top_tb.sv
// ubr_top_tb: self-checking bench for baud source selection and framing flag.
// assumes the package, design files and far-end model are compiled first.
`timescale 1ns/10ps
module ubr_top_tb;
  localparam int T1P = 5; // timer 1 overflow spacing in clocks
  localparam int M0P = 3; // fixed mode 0 clock spacing in clocks
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic timer1_ovf = 1'h0, mode0_fixed_tick = 1'h0, rx_frame_done, rx_stop_bit, ce;
  logic tx_baud_tick, rx_baud_tick, mode0_tick, baud_doubling, serial_mode_bit0;
  logic [7:0] rnd, rl;
  logic [15:0] t2rl;
  logic [7:0] codes [4] = '{8'h00, 8'h14, 8'h24, 8'h34};
  int miscompares, num_checks, cyc, m_fe, m_sm0, nstop;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  ubr_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer1_ovf(timer1_ovf),
    .mode0_fixed_tick(mode0_fixed_tick), .rx_frame_done(rx_frame_done),
    .rx_stop_bit(rx_stop_bit), .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick),
    .mode0_tick(mode0_tick), .baud_doubling(baud_doubling),
    .serial_mode_bit0(serial_mode_bit0));

  ubr_far_end far (.hclk(hclk), .rx_stop_bit(rx_stop_bit), .rx_frame_done(rx_frame_done));

  // ==========================================================================
  // clock and side sources
  // clock at 50 MHz
  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end

  // timer 1 overflow and fixed mode 0 pulses at fixed spacing
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    timer1_ovf <= (cyc % T1P) == 0;
    mode0_fixed_tick <= (cyc % M0P) == 0;
  end

  // ==========================================================================
  // helpers
  // pseudo-random byte source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // one comparison, mismatches reported at once
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // single ahb-lite word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= ubr_pkg::UBR_HTRANS_NONSEQ;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 100);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 100) miscompares++;
  endtask

  // register read compared under a mask
  task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp,
    input logic [31:0] m = 32'hffffffff);
    bus(1'h0, idx, 8'h00);
    chk(name, exp, rd & m);
  endtask

  // spacing between two later ticks of one output: 0 tx, 1 rx, 2 mode 0
  task automatic gapchk(input string name, input int which, input int exp);
    int g, k;
    logic t;
    g = 0;
    k = 0;
    for (int n = 0; n < 3000; n++) begin
      @(posedge hclk);
      t = which == 0 ? tx_baud_tick : which == 1 ? rx_baud_tick : mode0_tick;
      if (t === 1'h1) begin
        if (k == 2) break;
        k++;
        g = 0;
      end
      g++;
    end
    chk(name, 32'(exp), 32'(g));
  endtask

  // counts and verdict, then end of run
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog against a hang; timer 2 first rollover alone takes 65536 clocks
  initial begin
    repeat (90000) @(posedge hclk);
    miscompares++;
    stop_test;
  end

  // ==========================================================================
  // main sequence
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    ce = 1'h1;
    rnd = 8'h04;
    miscompares = 0;
    num_checks = 0;
    m_fe = 0;
    m_sm0 = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    // reset values, unused bits, unmapped place
    rdc("reload rst", ubr_pkg::UBR_IDX_RELOAD, 32'h0);
    rdc("ratectl rst", ubr_pkg::UBR_IDX_RATECTL, 32'h0);
    bus(1'h1, ubr_pkg::UBR_IDX_RATECTL, 8'hfe);
    rdc("ratectl", ubr_pkg::UBR_IDX_RATECTL, 32'h1e);
    bus(1'h1, ubr_pkg::UBR_IDX_RELOAD, 8'ha5);
    rdc("reload", ubr_pkg::UBR_IDX_RELOAD, 32'ha5);
    bus(1'h1, 8'h80, 8'h5a);
    rdc("unmapped", 8'h80, 32'h0);
    $display("test registers done");
    // counter against a running timer 2, fast then slow
    bus(1'h1, ubr_pkg::UBR_IDX_T2RLO, 8'hfd);
    bus(1'h1, ubr_pkg::UBR_IDX_T2RHI, 8'hff);
    bus(1'h1, ubr_pkg::UBR_IDX_T2CTL, 8'h34);
    // timer 2 starts at zero: let it reach its first reload
    repeat (65536) @(posedge hclk);
    for (int s = 1; s >= 0; s--) begin
      rnd = lfsr(rnd);
      rl = 8'he0 | (rnd & 8'h0f);
      bus(1'h1, ubr_pkg::UBR_IDX_RELOAD, rl);
      bus(1'h1, ubr_pkg::UBR_IDX_RATECTL, 8'h1d | 8'(s << 1));
      for (int w = 0; w < 3; w++) begin
        gapchk("counter gap", w, (256 - int'(rl)) * (s == 1 ? 1 : 6));
      end
    end
    // run cleared: counter silent, rx falls back to timer 2
    bus(1'h1, ubr_pkg::UBR_IDX_RATECTL, 8'h0b);
    gapchk("rx timer2 gap", 1, 3);
    nstop = 0;
    for (int n = 0; n < 400; n++) begin
      @(posedge hclk);
      if (tx_baud_tick === 1'h1) nstop++;
    end
    chk("stopped ticks", 32'h0, 32'(nstop));
    $display("test rate counter done");
    // every timer select code with counter selects clear
    bus(1'h1, ubr_pkg::UBR_IDX_RATECTL, 8'h00);
    rnd = lfsr(rnd);
    t2rl = 16'hffe0 | 16'(rnd & 8'h0f);
    bus(1'h1, ubr_pkg::UBR_IDX_T2RLO, t2rl[7:0]);
    bus(1'h1, ubr_pkg::UBR_IDX_T2RHI, t2rl[15:8]);
    foreach (codes[i]) begin
      bus(1'h1, ubr_pkg::UBR_IDX_T2CTL, codes[i]);
      gapchk("tx gap", 0, codes[i][4] ? 65536 - int'(t2rl) : T1P);
      gapchk("rx gap", 1, codes[i][5] ? 65536 - int'(t2rl) : T1P);
    end
    gapchk("mode0 fixed gap", 2, M0P);
    $display("test timer sources done");
    // framing flag and shared serial control bit
    bus(1'h1, ubr_pkg::UBR_IDX_PWRCTL, 8'hc0);
    repeat (2) @(posedge hclk);
    chk("doubling", 32'h1, {31'h0, baud_doubling});
    far.send_frame(1'h1);
    rdc("fe clean", ubr_pkg::UBR_IDX_SERCTL, 32'h0, 32'h80);
    far.send_frame(1'h0);
    m_fe = 1;
    rdc("fe set", ubr_pkg::UBR_IDX_SERCTL, 32'(m_fe << 7), 32'h80);
    bus(1'h1, ubr_pkg::UBR_IDX_PWRCTL, 8'h00);
    repeat (2) @(posedge hclk);
    chk("doubling", 32'h0, {31'h0, baud_doubling});
    rdc("mode view", ubr_pkg::UBR_IDX_SERCTL, 32'(m_sm0 << 7), 32'h80);
    bus(1'h1, ubr_pkg::UBR_IDX_SERCTL, 8'h80);
    m_sm0 = 1;
    repeat (2) @(posedge hclk);
    chk("mode out", 32'(m_sm0), {31'h0, serial_mode_bit0});
    rdc("fe kept", ubr_pkg::UBR_IDX_STATUS, 32'(m_fe), 32'h1);
    bus(1'h1, ubr_pkg::UBR_IDX_PWRCTL, 8'h40);
    bus(1'h1, ubr_pkg::UBR_IDX_SERCTL, 8'h00);
    m_fe = 0;
    rdc("fe cleared", ubr_pkg::UBR_IDX_SERCTL, 32'(m_fe << 7), 32'h80);
    chk("mode kept", 32'(m_sm0), {31'h0, serial_mode_bit0});
    bus(1'h1, ubr_pkg::UBR_IDX_PWRCTL, 8'h00);
    far.send_frame(1'h0);
    m_fe = 1;
    rdc("fe any select", ubr_pkg::UBR_IDX_STATUS, 32'(m_fe), 32'h1);
    $display("test framing done");
    // clock enable low: a write is not taken and state holds
    ce <= 1'h0;
    bus(1'h1, ubr_pkg::UBR_IDX_PWRCTL, 8'hc0);
    ce <= 1'h1;
    rdc("ce frozen", ubr_pkg::UBR_IDX_PWRCTL, 32'h0);
    $display("test clock enable done");
    stop_test;
  end
endmodule
